// file: rtl/ptg_top.sv
// prbs test pattern generator and receive checker
// Contract
// - 511: 9 stages, taps 5 and 9
// - 511 starts at first of nine ones
// - 2047: 11 stages, taps 9 and 11
// - 8-bit groups fill consecutive time slots
// - 32767: taps 14 and 15, inverted
// - plain 2^20: taps 3 and 20
// - zero-suppressed 2^20: taps 17 and 20
// - force one when next 14 zero
// - 2^23: taps 18 and 23, inverted
// - 2^29: taps 27 and 29, inverted
// - 2^31: taps 28 and 31, inverted
// - two 20-stage patterns kept distinct
// - error ratio 0.20 in 1 s loses sync
// - out-of-phase error pattern loses sync
// - pause sequence during frame alignment bits
`timescale 1ns/100ps
module ptg_top
    import ptg_pkg::*;
#(
    parameter int INTEG_CYCLES = INTEG_CYC,
    parameter int DEPTH        = FIFO_DEPTH
) (
    input  wire logic              CLK_SYS_I,
    input  wire logic              RESET_N_I,
    input  wire logic [2:0]        PAT_SEL_I,
    input  wire logic              BIT_EN_I,
    input  wire logic              FRAME_ALIGN_I,
    input  wire logic              FRAME_ALIGN_BIT_I,
    output logic                   TX_BIT_O,
    output logic                   TX_VALID_O,
    output logic [BYTE_W-1:0]      SLOT_BYTE_O,
    output logic                   SLOT_VALID_O,
    input  wire logic              SLOT_READY_I,
    input  wire logic              RX_BIT_I,
    input  wire logic              RX_VALID_I,
    output logic                   SYNC_O,
    output logic                   ERR_O,
    output logic                   LOSS_O,
    output logic [31:0]            ERR_CNT_O
);
    ptg_pat_t          sel_r;
    ptg_state_t        state_r;
    logic [GEN_W-1:0]  gen_q_r;
    logic [GEN_W-1:0]  ref_q_r;
    logic [GEN_W-1:0]  eh_r;
    logic [ZS_RUN-1:0] dly_r;
    logic [4:0]        len;
    logic [4:0]        tap;
    logic              inv;
    logic              zs;
    logic              reload;
    logic              adv;
    logic              gen_fb;
    logic              gen_out;
    logic [BYTE_W-2:0] pack_r;
    logic [2:0]        pcnt_r;
    logic              rx_raw;
    logic              pred;
    logic              chk_out;
    logic              rx_cmp;
    logic              mism;
    logic              ph_ok;
    logic [6:0]        mcnt_r;
    logic [6:0]        pcnt_ph_r;
    logic [31:0]       win_r;
    logic [31:0]       bits_r;
    logic [31:0]       errs_r;
    logic              win_end;
    logic              ber_loss;
    logic              ph_loss;
    logic              lose;
    ptg_fifo_if #(.W(BYTE_W)) f_in ();
    ptg_fifo_if #(.W(BYTE_W)) f_out ();

    // pattern decode: stage count, second tap, inversion
    always_comb begin
        len = P9_LEN;
        tap = P9_TAP;
        inv = 1'b0;
        zs  = 1'b0;
        case (sel_r)
            PAT_9: begin
                len = P9_LEN;
                tap = P9_TAP;
            end
            PAT_11: begin
                len = P11_LEN;
                tap = P11_TAP;
            end
            PAT_15: begin
                len = P15_LEN;
                tap = P15_TAP;
                inv = 1'b1;
            end
            PAT_20: begin
                len = P20_LEN;
                tap = P20_TAP;
            end
            PAT_20Z: begin
                len = P20_LEN;
                tap = P20Z_TAP;
                zs  = 1'b1;
            end
            PAT_23: begin
                len = P23_LEN;
                tap = P23_TAP;
                inv = 1'b1;
            end
            PAT_29: begin
                len = P29_LEN;
                tap = P29_TAP;
                inv = 1'b1;
            end
            PAT_31: begin
                len = P31_LEN;
                tap = P31_TAP;
                inv = 1'b1;
            end
        endcase
    end

    // selection register; a change reloads both shift registers
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sel_r <= PAT_9;
        end else begin
            sel_r <= ptg_pat_t'(PAT_SEL_I);
        end
    end
    assign reload = (PAT_SEL_I != sel_r);

    // generator feedback and output
    assign adv     = BIT_EN_I & ~FRAME_ALIGN_I & f_in.ready & ~reload;
    assign gen_fb  = gen_q_r[len-1] ^ gen_q_r[tap-1];
    assign gen_out = zs ? (gen_q_r[len-1] | ~|gen_q_r[ZS_HI:ZS_LO])
                        : (gen_q_r[len-1] ^ inv);

    // generator shift register, seeded with all ones
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            gen_q_r <= GEN_SEED;
        end else if (reload) begin
            gen_q_r <= GEN_SEED;
        end else if (adv) begin
            gen_q_r <= {gen_q_r[GEN_W-2:0], gen_fb};
        end
    end

    // serial output; frame alignment bits take the place of the sequence
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            TX_BIT_O   <= 1'b0;
            TX_VALID_O <= 1'b0;
        end else if (BIT_EN_I && FRAME_ALIGN_I) begin
            TX_BIT_O   <= FRAME_ALIGN_BIT_I;
            TX_VALID_O <= 1'b1;
        end else if (adv) begin
            TX_BIT_O   <= gen_out;
            TX_VALID_O <= 1'b1;
        end else begin
            TX_VALID_O <= 1'b0;
        end
    end

    // pack consecutive bits into slot bytes, first bit in the msb
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pack_r <= '0;
            pcnt_r <= '0;
        end else if (reload) begin
            pcnt_r <= '0;
        end else if (adv) begin
            pack_r <= {pack_r[BYTE_W-3:0], gen_out};
            pcnt_r <= pcnt_r + 1'b1;
        end
    end
    assign f_in.valid = adv & (pcnt_r == 3'h7);
    assign f_in.data  = {pack_r, gen_out};

    ptg_fifo #(.W(BYTE_W), .D(DEPTH)) u_fifo (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RESET_N_I),
        .wr      (f_in),
        .rd      (f_out)
    );

    // slot output stage
    assign f_out.ready = ~SLOT_VALID_O | SLOT_READY_I;
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SLOT_VALID_O <= 1'b0;
            SLOT_BYTE_O  <= '0;
        end else if (f_out.ready) begin
            SLOT_VALID_O <= f_out.valid;
            SLOT_BYTE_O  <= f_out.data;
        end
    end

    // checker reference: recurrence on the received stream
    assign rx_raw  = RX_BIT_I ^ inv;
    assign pred    = ref_q_r[len-1] ^ ref_q_r[tap-1];
    assign chk_out = zs ? (ref_q_r[ZS_RUN-1] | ~|{ref_q_r[ZS_RUN-2:0], pred}) : pred;
    assign rx_cmp  = zs ? dly_r[ZS_RUN-1] : rx_raw;
    assign mism    = rx_cmp ^ chk_out;
    assign ph_ok   = (mism == (eh_r[len-1] ^ eh_r[tap-1])) & (|eh_r);
    // reference register: loads from line while hunting, free runs in sync
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ref_q_r <= GEN_SEED;
            dly_r   <= '0;
        end else if (reload) begin
            ref_q_r <= GEN_SEED;
        end else if (RX_VALID_I) begin
            dly_r   <= {dly_r[ZS_RUN-2:0], RX_BIT_I};
            ref_q_r <= {ref_q_r[GEN_W-2:0], (state_r == ST_HUNT) ? rx_raw : pred};
        end
    end
    // one second integration window
    assign win_end  = (win_r == 32'(INTEG_CYCLES - 1));
    assign ber_loss = win_end && (bits_r != '0)
                      && (35'(errs_r) * 35'(BER_DEN) >= 35'(bits_r));
    assign ph_loss  = RX_VALID_I && ph_ok && (pcnt_ph_r == 7'(PHASE_MATCH - 1));
    assign lose     = (state_r == ST_SYNC) && (ber_loss || ph_loss);
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            win_r  <= '0;
            bits_r <= '0;
            errs_r <= '0;
        end else if (win_end || lose || reload) begin
            win_r  <= '0;
            bits_r <= '0;
            errs_r <= '0;
        end else begin
            win_r <= win_r + 1'b1;
            if (RX_VALID_I && state_r == ST_SYNC) begin
                bits_r <= bits_r + 1'b1;
                errs_r <= errs_r + 32'(mism);
            end
        end
    end

    // error history for out-of-phase detection
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            eh_r      <= '0;
            pcnt_ph_r <= '0;
        end else if (reload || state_r != ST_SYNC || lose) begin
            eh_r      <= '0;
            pcnt_ph_r <= '0;
        end else if (RX_VALID_I) begin
            eh_r      <= {eh_r[GEN_W-2:0], mism};
            pcnt_ph_r <= ph_ok ? pcnt_ph_r + 1'b1 : '0;
        end
    end

    // sync state machine
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= ST_HUNT;
            mcnt_r  <= '0;
        end else if (reload) begin
            state_r <= ST_HUNT;
            mcnt_r  <= '0;
        end else begin
            case (state_r)
                ST_HUNT: begin
                    if (RX_VALID_I) begin
                        if (mism || !(|ref_q_r)) begin
                            mcnt_r <= '0;
                        end else if (mcnt_r == 7'(SYNC_MATCH - 1)) begin
                            state_r <= ST_SYNC;
                            mcnt_r  <= '0;
                        end else begin
                            mcnt_r <= mcnt_r + 1'b1;
                        end
                    end
                end
                ST_SYNC: begin
                    if (lose) begin
                        state_r <= ST_HUNT;
                    end
                end
                default: begin
                    state_r <= ST_HUNT;
                end
            endcase
        end
    end

    // status outputs and saturating error count
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            SYNC_O    <= 1'b0;
            ERR_O     <= 1'b0;
            LOSS_O    <= 1'b0;
            ERR_CNT_O <= '0;
        end else begin
            SYNC_O <= (state_r == ST_SYNC) && !lose && !reload;
            LOSS_O <= lose;
            ERR_O  <= RX_VALID_I && (state_r == ST_SYNC) && mism && !reload;
            if (reload) begin
                ERR_CNT_O <= '0;
            end else if (RX_VALID_I && state_r == ST_SYNC && mism && ~&ERR_CNT_O) begin
                ERR_CNT_O <= ERR_CNT_O + 1'b1;
            end
        end
    end

    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    AST_GEN_NONZERO: assert property (gen_q_r != '0)
        else $error("generator register reached zero");
    AST_SEED_ONES: assert property (reload |=> gen_q_r == GEN_SEED)
        else $error("seed not loaded on selection change");
    AST_TAP_9: assert property ((sel_r == PAT_9) && adv |=>
        gen_q_r[0] == ($past(gen_q_r[4]) ^ $past(gen_q_r[8])))
        else $error("511 feedback wrong");
    AST_TAP_11: assert property ((sel_r == PAT_11) && adv |=>
        gen_q_r[0] == ($past(gen_q_r[8]) ^ $past(gen_q_r[10])))
        else $error("2047 feedback wrong");
    AST_TAP_20Z: assert property ((sel_r == PAT_20Z) && adv |=>
        gen_q_r[0] == ($past(gen_q_r[16]) ^ $past(gen_q_r[19])))
        else $error("zero suppressed feedback wrong");
    AST_INV_31: assert property ((sel_r == PAT_31) && adv |=>
        TX_BIT_O == !$past(gen_q_r[30]) && TX_VALID_O)
        else $error("31 stage output not inverted");
    AST_ZS_FORCE: assert property ((sel_r == PAT_20Z) && adv && !(|gen_q_r[18:5]) |=>
        TX_BIT_O)
        else $error("zero run not suppressed");
    AST_FRAME_PAUSE: assert property (BIT_EN_I && FRAME_ALIGN_I && !reload |=>
        $stable(gen_q_r) && TX_BIT_O == $past(FRAME_ALIGN_BIT_I))
        else $error("sequence advanced during frame alignment");
    AST_BYTE_PUSH: assert property (f_in.valid |=>
        TX_VALID_O && TX_BIT_O == $past(f_in.data[0]))
        else $error("slot byte differs from sent bits");
    AST_BER_LOSS: assert property (lose |=> LOSS_O && !SYNC_O && state_r == ST_HUNT)
        else $error("loss not declared");
    AST_ERR_COUNT: assert property (RX_VALID_I && state_r == ST_SYNC && mism && !reload
        && ERR_CNT_O != 32'hffffffff |=> ERR_O && ERR_CNT_O == $past(ERR_CNT_O) + 32'h1)
        else $error("bit error not counted");
endmodule // ptg_top

// file: rtl/ptg_pkg.sv
// shared constants and types for the prbs generator and checker
package ptg_pkg;
    // pattern selection codes
    typedef enum logic [2:0] {
        PAT_9   = 3'h0,
        PAT_11  = 3'h1,
        PAT_15  = 3'h2,
        PAT_20  = 3'h3,
        PAT_20Z = 3'h4,
        PAT_23  = 3'h5,
        PAT_29  = 3'h6,
        PAT_31  = 3'h7
    } ptg_pat_t;

    // checker state, one-hot
    typedef enum logic [1:0] {
        ST_HUNT = 2'h1,
        ST_SYNC = 2'h2
    } ptg_state_t;

    // register width and seed (all ones, never zero)
    localparam int          GEN_W    = 31;
    localparam logic [30:0] GEN_SEED = 31'h7fffffff;

    // stage counts and second feedback stage per pattern
    localparam logic [4:0] P9_LEN  = 5'h09;
    localparam logic [4:0] P9_TAP  = 5'h05;
    localparam logic [4:0] P11_LEN = 5'h0b;
    localparam logic [4:0] P11_TAP = 5'h09;
    localparam logic [4:0] P15_LEN = 5'h0f;
    localparam logic [4:0] P15_TAP = 5'h0e;
    localparam logic [4:0] P20_LEN = 5'h14;
    localparam logic [4:0] P20_TAP = 5'h03;
    localparam logic [4:0] P20Z_TAP = 5'h11;
    localparam logic [4:0] P23_LEN = 5'h17;
    localparam logic [4:0] P23_TAP = 5'h12;
    localparam logic [4:0] P29_LEN = 5'h1d;
    localparam logic [4:0] P29_TAP = 5'h1b;
    localparam logic [4:0] P31_LEN = 5'h1f;
    localparam logic [4:0] P31_TAP = 5'h1c;

    // zero suppression: look-ahead of 14 stages (stages 6 to 19)
    localparam int ZS_RUN = 14;
    localparam int ZS_LO  = 5;
    localparam int ZS_HI  = 18;

    // time slot grouping and buffer size
    localparam int BYTE_W     = 8;
    localparam int FIFO_DEPTH = 16;

    // loss of sync: bit error ratio 0.20 = 1/5 over 1 s
    localparam int CLK_HZ        = 25_000_000;
    localparam int INTEG_TIME_MS = 1000;
    localparam int INTEG_CYC     = CLK_HZ / 1000 * INTEG_TIME_MS;
    localparam int BER_DEN       = 5;

    // matches needed to gain sync and to call an out-of-phase state
    localparam int SYNC_MATCH  = 64;
    localparam int PHASE_MATCH = 64;
endpackage

// file: rtl/ptg_fifo_if.sv
// valid/ready word stream between generator and buffer
`timescale 1ns/100ps
interface ptg_fifo_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: rtl/ptg_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module ptg_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    ptg_fifo_if.snk   wr,
    ptg_fifo_if.src   rd
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    // honest full and empty from the fill count
    assign wr.ready = (cnt_r != (AW+1)'(D));
    assign rd.valid = (cnt_r != '0);
    assign rd.data  = mem_r[rp_r];
    assign push     = wr.valid & wr.ready;
    assign pop      = rd.valid & rd.ready;

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= wr.data;
        end
    end

    // pointers and count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // ptg_fifo

// file: testbench/ptg_eut_model.sv
// loopback model of the equipment under test with error injection
`timescale 1ns/100ps
module ptg_eut_model (
    input  wire logic clk_i,
    input  wire logic tx_bit_i,
    input  wire logic tx_valid_i,
    input  wire logic flip_one_i,
    input  wire logic flip_all_i,
    input  wire logic slip_i,
    output logic      rx_bit_o,
    output logic      rx_valid_o
);
    initial begin
        rx_bit_o   = 1'b0;
        rx_valid_o = 1'b0;
    end

    // returns each bit one cycle later, idle line toggles so no stale value
    always @(posedge clk_i) begin
        #2;
        if (tx_valid_i && !slip_i) begin
            rx_bit_o   = tx_bit_i ^ flip_all_i ^ flip_one_i;
            rx_valid_o = 1'b1;
        end else begin
            rx_bit_o   = ~rx_bit_o;
            rx_valid_o = 1'b0;
        end
    end
endmodule // ptg_eut_model

// file: testbench/test_prbs_test_pattern_gen_check.sv
// self-checking bench for the prbs generator and checker
`timescale 1ns/100ps
module test_prbs_test_pattern_gen_check
    import ptg_pkg::*;
;
    localparam int INTEG = 2000;

    logic        clk_sys, reset_n, bit_en, frame_align, frame_bit, slot_ready;
    logic        tx_bit, tx_valid, slot_valid, rx_bit, rx_valid, sync, err, loss;
    logic        flip_one, flip_all, slip;
    logic [2:0]  pat_sel;
    logic [7:0]  slot_byte;
    logic [31:0] err_cnt;
    logic [30:0] ref_q;
    logic        q_tx[$];
    logic [7:0]  q_slot[$];
    int          err_total, compares, n_err, n_loss;

    // stage count, feedback stage and inversion per pattern code
    int   len_t[8] = '{9, 11, 15, 20, 20, 23, 29, 31};
    int   tap_t[8] = '{5, 9, 14, 3, 17, 18, 27, 28};
    logic inv_t[8] = '{0, 0, 1, 0, 0, 1, 1, 1};

    ptg_top #(.INTEG_CYCLES(INTEG), .DEPTH(16)) uut (
        .CLK_SYS_I(clk_sys), .RESET_N_I(reset_n), .PAT_SEL_I(pat_sel),
        .BIT_EN_I(bit_en), .FRAME_ALIGN_I(frame_align), .FRAME_ALIGN_BIT_I(frame_bit),
        .TX_BIT_O(tx_bit), .TX_VALID_O(tx_valid), .SLOT_BYTE_O(slot_byte),
        .SLOT_VALID_O(slot_valid), .SLOT_READY_I(slot_ready), .RX_BIT_I(rx_bit),
        .RX_VALID_I(rx_valid), .SYNC_O(sync), .ERR_O(err), .LOSS_O(loss),
        .ERR_CNT_O(err_cnt)
    );

    ptg_eut_model eut (
        .clk_i(clk_sys), .tx_bit_i(tx_bit), .tx_valid_i(tx_valid),
        .flip_one_i(flip_one), .flip_all_i(flip_all), .slip_i(slip),
        .rx_bit_o(rx_bit), .rx_valid_o(rx_valid)
    );

    // clock generator
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // collect sent bits, taken slot bytes and event pulses
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1) q_tx.push_back(tx_bit);
        if (slot_valid === 1'b1 && slot_ready === 1'b1) q_slot.push_back(slot_byte);
        if (err === 1'b1) n_err++;
        if (loss === 1'b1) n_loss++;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // next reference bit, register seeded all ones
    task automatic ref_step(input logic [2:0] p, output logic b);
        b = ref_q[len_t[p]-1] ^ inv_t[p];
        if (p == 3'h4) b = ref_q[19] | ~(|ref_q[18:5]);
        ref_q = {ref_q[29:0], ref_q[tap_t[p]-1] ^ ref_q[len_t[p]-1]};
    endtask

    task automatic reload(input logic [2:0] p);
        bit_en  = 1'b0;
        pat_sel = p;
        tick(4);
        q_tx.delete();
        q_slot.delete();
        ref_q = 31'h7fffffff;
    endtask

    // every pattern from its seed, 64 bits each
    task automatic test_patterns();
        logic b;
        for (int p = 0; p < 8; p++) begin
            reload(3'(p));
            bit_en = 1'b1;
            tick(64);
            bit_en = 1'b0;
            tick(3);
            chk("tx count", 32'(q_tx.size()), 32'd64);
            for (int i = 0; i < 64; i++) begin
                ref_step(3'(p), b);
                chk("tx bit", 32'(q_tx[i]), 32'(b));
            end
        end
    endtask

    // framed bits, then fill the buffer while the slot side stalls, then drain
    task automatic test_slots();
        logic       b;
        logic [7:0] e;
        logic [7:0] eb[$];
        int         nb;
        int         n;
        reload(3'h1);
        nb = 0;
        for (int i = 0; i < 100; i++) begin
            frame_align = (i % 10 == 3);
            frame_bit   = (i % 20 == 3);
            bit_en      = 1'b1;
            tick(1);
        end
        bit_en      = 1'b0;
        frame_align = 1'b0;
        tick(4);
        chk("framed tx count", 32'(q_tx.size()), 32'd100);
        for (int i = 0; i < 100; i++) begin
            if (i % 10 == 3) begin
                b = (i % 20 == 3);
            end else begin
                ref_step(3'h1, b);
                e = {e[6:0], b};
                nb++;
                if (nb % 8 == 0) eb.push_back(e);
            end
            chk("framed tx bit", 32'(q_tx[i]), 32'(b));
        end
        q_tx.delete();
        slot_ready = 1'b0;
        bit_en     = 1'b1;
        tick(250);
        n = q_tx.size();
        tick(20);
        chk("stalled tx count", 32'(q_tx.size()), 32'(n));
        chk("fill bound", 32'(n), 32'((FIFO_DEPTH + 1) * BYTE_W - 90 % BYTE_W));
        bit_en = 1'b0;
        tick(2);
        slot_ready = 1'b1;
        tick(40);
        for (int i = 0; i < n; i++) begin
            ref_step(3'h1, b);
            e = {e[6:0], b};
            nb++;
            if (nb % 8 == 0) eb.push_back(e);
        end
        chk("slot count", 32'(q_slot.size()), 32'(eb.size()));
        foreach (eb[i]) chk("slot byte", 32'(q_slot[i]), 32'(eb[i]));
    endtask

    task automatic wait_sync();
        for (int i = 0; i < 300 && sync !== 1'b1; i++) tick(1);
        chk("sync gained", 32'(sync), 32'd1);
    endtask

    // fresh pattern: single error, error ratio loss, then a slipped bit
    task automatic test_checker();
        reload(3'h3);
        bit_en = 1'b1;
        wait_sync();
        tick(5);
        n_err  = 0;
        n_loss = 0;
        chk("count in sync", err_cnt, 32'd0);
        flip_one = 1'b1;
        tick(1);
        flip_one = 1'b0;
        tick(6);
        chk("error pulses", 32'(n_err), 32'd1);
        chk("error count", err_cnt, 32'd1);
        flip_all = 1'b1;
        tick(2 * INTEG + 50);
        chk("ratio loss", 32'(n_loss), 32'd1);
        chk("sync after ratio loss", 32'(sync), 32'd0);
        flip_all = 1'b0;
        wait_sync();
        n_loss = 0;
        slip   = 1'b1;
        tick(1);
        slip = 1'b0;
        tick(250);
        chk("phase loss", 32'(n_loss), 32'd1);
        chk("resync after slip", 32'(sync), 32'd1);
        bit_en = 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        reset_n     = 1'b0;
        pat_sel     = 3'h0;
        bit_en      = 1'b0;
        frame_align = 1'b0;
        frame_bit   = 1'b1;
        slot_ready  = 1'b1;
        flip_one    = 1'b0;
        flip_all    = 1'b0;
        slip        = 1'b0;
        err_total   = 0;
        compares    = 0;
        n_err       = 0;
        n_loss      = 0;
        repeat (2) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        tick(2);
        test_patterns();
        test_slots();
        test_checker();
        end_of_test();
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("BAD watchdog expected done seen hang");
        end_of_test();
    end
endmodule // test_prbs_test_pattern_gen_check
